// >>> core/pvm_mode_ctrl.sv
// Vendor mode control register and its datapath controls
// What this block does
// - Repeater mode refuses full duplex; carrier sense follows receive activity only.
// - Repeater mode at 10 Mb/s suppresses the heartbeat test.
// - Interrupt level select chooses active high or active low interrupt output.
// - Transmit float bit floats both transmit pins; receive pins stay working.
// - Heartbeat inhibit bit stops every heartbeat test.
// - Without inhibit, at 10 Mb/s outside repeater mode, a collision pulse follows each finished transmit frame.
// - Natural loop at 10 Mb/s loops transmit data onto receive path.
// - Reset value 0x0140, reserved bits 9:6 hold 0x05, mode bits clear.
// - Auto polarity disable bit turns automatic correction off.
// - Auto polarity at 10 Mb/s inverts receive when reversed wiring found.
// - With auto polarity on, inversion bit is read-only status.
// - With auto polarity off, inversion bit is writable and forces inversion.
// - Coding sublayer bypass at 100 Mb/s skips PCS and scrambler.
// - Receive clock gating at 100 Mb/s stops receive clock when idle.
// - Basic loop bit cancels receive clock gating.
`timescale 1ns/100ps
module pvm_mode_ctrl (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [4:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   input wire logic [1:0] link_speed,
   input wire logic full_duplex_req,
   input wire logic rx_activity,
   input wire logic tx_activity,
   input wire logic basic_loop_bit,
   input wire logic pol_reversed_det,
   input wire logic phy_irq_event,
   input wire logic tx_pair_pos_d,
   input wire logic tx_pair_neg_d,
   output logic irq_pin,
   output logic full_duplex_en,
   output logic carrier_sense,
   output logic collision,
   output logic tx_pair_pos_o,
   output logic tx_pair_pos_oe,
   output logic tx_pair_neg_o,
   output logic tx_pair_neg_oe,
   output logic rx_loop_sel,
   output logic rx_invert,
   output logic pcs_bypass,
   output logic rx_clk_gate_en
);
   import pvm_pkg::*;
   logic rst_s1_r, rst_n_r;
   logic [31:0] mode_r, mode_nxt;
   logic auto_inv_r, auto_inv_nxt;
   logic ten_meg, hundred_meg, sqe_en, sqe_pulse;
   logic [31:0] rdata_nxt;
   logic irq_pin_nxt, full_duplex_en_nxt, carrier_sense_nxt, collision_nxt;
   logic tx_pair_pos_o_nxt, tx_pair_pos_oe_nxt, tx_pair_neg_o_nxt, tx_pair_neg_oe_nxt;
   logic rx_loop_sel_nxt, rx_invert_nxt, pcs_bypass_nxt, rx_clk_gate_en_nxt;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end
   assign ten_meg = (link_speed == PVM_SPEED_10);
   assign hundred_meg = (link_speed == PVM_SPEED_100);
   always_comb begin
      mode_nxt = mode_r;
      if (reg_wr && reg_addr == PVM_ADDR_MODE) begin
         mode_nxt = (mode_r & ~PVM_WRITE_MASK) | (reg_wdata & PVM_WRITE_MASK);
         if (!reg_wdata[PVM_BIT_APOLDIS]) begin
            mode_nxt[PVM_BIT_RXINV] = mode_r[PVM_BIT_RXINV];
         end
      end
      auto_inv_nxt = auto_inv_r;
      if (mode_r[PVM_BIT_APOLDIS]) begin
         auto_inv_nxt = 1'b0;
      end else if (ten_meg) begin
         auto_inv_nxt = pol_reversed_det;
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mode_r <= PVM_RESET_VAL;
         auto_inv_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         auto_inv_r <= auto_inv_nxt;
      end
   end
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (reg_addr == PVM_ADDR_MODE) begin
         rdata_nxt = mode_r;
         if (!mode_r[PVM_BIT_APOLDIS]) begin
            rdata_nxt[PVM_BIT_RXINV] = auto_inv_r;
         end
      end
   end
   assign sqe_en = !mode_r[PVM_BIT_HEARTBEAT_TEST_INHIBIT] && ten_meg && !mode_r[PVM_BIT_RPT];
   pvm_sqe_gen u_sqe (
      .sys_clk(sys_clk),
      .rst_n(rst_n_r),
      .enable(sqe_en),
      .tx_active(tx_activity),
      .sqe_pulse(sqe_pulse)
   );
   always_comb begin
      irq_pin_nxt = mode_r[PVM_BIT_IRQPOL] ? phy_irq_event : !phy_irq_event;
      full_duplex_en_nxt = full_duplex_req && !mode_r[PVM_BIT_RPT];
      carrier_sense_nxt = mode_r[PVM_BIT_RPT] ? rx_activity : (rx_activity || tx_activity);
      collision_nxt = sqe_pulse && sqe_en;
      tx_pair_pos_o_nxt = tx_pair_pos_d;
      tx_pair_neg_o_nxt = tx_pair_neg_d;
      tx_pair_pos_oe_nxt = !mode_r[PVM_BIT_TXFLOAT];
      tx_pair_neg_oe_nxt = !mode_r[PVM_BIT_TXFLOAT];
      rx_loop_sel_nxt = mode_r[PVM_BIT_NLOOP] && ten_meg;
      rx_invert_nxt = mode_r[PVM_BIT_APOLDIS] ? mode_r[PVM_BIT_RXINV] : auto_inv_r;
      pcs_bypass_nxt = mode_r[PVM_BIT_CODING_SUBLAYER_BYPASS] && hundred_meg;
      rx_clk_gate_en_nxt = mode_r[PVM_BIT_RX_CLOCK_GATING] && hundred_meg && !basic_loop_bit && !rx_activity;
   end
   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         reg_rdata <= 32'h0000_0000;
         irq_pin <= 1'b1;
         full_duplex_en <= 1'b0;
         carrier_sense <= 1'b0;
         collision <= 1'b0;
         tx_pair_pos_o <= 1'b0;
         tx_pair_pos_oe <= 1'b0;
         tx_pair_neg_o <= 1'b0;
         tx_pair_neg_oe <= 1'b0;
         rx_loop_sel <= 1'b0;
         rx_invert <= 1'b0;
         pcs_bypass <= 1'b0;
         rx_clk_gate_en <= 1'b0;
      end else begin
         reg_rdata <= rdata_nxt;
         irq_pin <= irq_pin_nxt;
         full_duplex_en <= full_duplex_en_nxt;
         carrier_sense <= carrier_sense_nxt;
         collision <= collision_nxt;
         tx_pair_pos_o <= tx_pair_pos_o_nxt;
         tx_pair_neg_o <= tx_pair_neg_o_nxt;
         tx_pair_pos_oe <= tx_pair_pos_oe_nxt;
         tx_pair_neg_oe <= tx_pair_neg_oe_nxt;
         rx_loop_sel <= rx_loop_sel_nxt;
         rx_invert <= rx_invert_nxt;
         pcs_bypass <= pcs_bypass_nxt;
         rx_clk_gate_en <= rx_clk_gate_en_nxt;
      end
   end

   property p_rst_val;
      @(posedge sys_clk) $rose(rst_n_r) |-> mode_r == PVM_RESET_VAL;
   endproperty
   a_rst_val: assert property (p_rst_val) else $error("reset value wrong");
   property p_fdx;
      @(posedge sys_clk) disable iff (!rst_n_r) mode_r[PVM_BIT_RPT] |=> !full_duplex_en;
   endproperty
   a_fdx: assert property (p_fdx) else $error("full duplex in repeater");
   property p_irq;
      @(posedge sys_clk) disable iff (!rst_n_r)
         !mode_r[PVM_BIT_IRQPOL] && phy_irq_event |=> !irq_pin;
   endproperty
   a_irq: assert property (p_irq) else $error("irq level wrong");
   property p_float;
      @(posedge sys_clk) disable iff (!rst_n_r) mode_r[PVM_BIT_TXFLOAT] |=> !tx_pair_pos_oe && !tx_pair_neg_oe;
   endproperty
   a_float: assert property (p_float) else $error("tx not floated");
   property p_heartbeat_test_inhibit;
      @(posedge sys_clk) disable iff (!rst_n_r) mode_r[PVM_BIT_HEARTBEAT_TEST_INHIBIT] |=> !collision;
   endproperty
   a_heartbeat_test_inhibit: assert property (p_heartbeat_test_inhibit) else $error("heartbeat while inhibited");
   property p_sqe;
      @(posedge sys_clk) disable iff (!rst_n_r)
         $fell(tx_activity) && sqe_en && $past(tx_activity, 2) ##1 sqe_en |=> collision;
   endproperty
   a_sqe: assert property (p_sqe) else $error("missing heartbeat");
   property p_loop;
      @(posedge sys_clk) disable iff (!rst_n_r) mode_r[PVM_BIT_NLOOP] && ten_meg |=> rx_loop_sel;
   endproperty
   a_loop: assert property (p_loop) else $error("loop not selected");
   property p_ro;
      @(posedge sys_clk) disable iff (!rst_n_r)
         !mode_r[PVM_BIT_APOLDIS] && !(reg_wr && reg_addr == PVM_ADDR_MODE && reg_wdata[PVM_BIT_APOLDIS])
         |=> $stable(mode_r[PVM_BIT_RXINV]);
   endproperty
   a_ro: assert property (p_ro) else $error("inversion bit changed");
   property p_rx_clock_gating;
      @(posedge sys_clk) disable iff (!rst_n_r) basic_loop_bit |=> !rx_clk_gate_en;
   endproperty
   a_rx_clock_gating: assert property (p_rx_clock_gating) else $error("gating during loop");
   property p_resv;
      @(posedge sys_clk) disable iff (!rst_n_r) (mode_r & PVM_RESERVED_MASK) == (PVM_RESET_VAL & PVM_RESERVED_MASK);
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bits changed");
   property p_fdx_on;
      @(posedge sys_clk) disable iff (!rst_n_r)
         !mode_r[PVM_BIT_RPT] |=> full_duplex_en == $past(full_duplex_req);
   endproperty
   a_fdx_on: assert property (p_fdx_on) else $error("duplex request not passed");
   property p_cs_rpt;
      @(posedge sys_clk) disable iff (!rst_n_r)
         mode_r[PVM_BIT_RPT] |=> carrier_sense == $past(rx_activity);
   endproperty
   a_cs_rpt: assert property (p_cs_rpt) else $error("carrier not from receive");
   property p_rpt_sqe;
      @(posedge sys_clk) disable iff (!rst_n_r)
         mode_r[PVM_BIT_RPT] && ten_meg |=> !collision;
   endproperty
   a_rpt_sqe: assert property (p_rpt_sqe) else $error("heartbeat in repeater");
   property p_irq_idle;
      @(posedge sys_clk) disable iff (!rst_n_r)
         !mode_r[PVM_BIT_IRQPOL] && !phy_irq_event |=> irq_pin;
   endproperty
   a_irq_idle: assert property (p_irq_idle) else $error("irq idle level wrong");
   property p_tx_on;
      @(posedge sys_clk) disable iff (!rst_n_r)
         !mode_r[PVM_BIT_TXFLOAT] |=> tx_pair_pos_oe && tx_pair_neg_oe;
   endproperty
   a_tx_on: assert property (p_tx_on) else $error("tx not driven");
   property p_sqe_once;
      @(posedge sys_clk) disable iff (!rst_n_r)
         collision |=> !collision;
   endproperty
   a_sqe_once: assert property (p_sqe_once) else $error("heartbeat too long");
   property p_loop_off;
      @(posedge sys_clk) disable iff (!rst_n_r)
         !ten_meg |=> !rx_loop_sel;
   endproperty
   a_loop_off: assert property (p_loop_off) else $error("loop outside 10 Mb/s");
   property p_loop_clr;
      @(posedge sys_clk) disable iff (!rst_n_r)
         !mode_r[PVM_BIT_NLOOP] |=> !rx_loop_sel;
   endproperty
   a_loop_clr: assert property (p_loop_clr) else $error("loop without enable");
   property p_auto_pol_disable_off;
      @(posedge sys_clk) disable iff (!rst_n_r)
         mode_r[PVM_BIT_APOLDIS] |=> !auto_inv_r;
   endproperty
   a_auto_pol_disable_off: assert property (p_auto_pol_disable_off) else $error("auto polarity not off");
   property p_auto_inv;
      @(posedge sys_clk) disable iff (!rst_n_r)
         !mode_r[PVM_BIT_APOLDIS] && ten_meg |=> auto_inv_r == $past(pol_reversed_det);
   endproperty
   a_auto_inv: assert property (p_auto_inv) else $error("auto polarity not tracked");
   property p_auto_out;
      @(posedge sys_clk) disable iff (!rst_n_r)
         !mode_r[PVM_BIT_APOLDIS] |=> rx_invert == $past(auto_inv_r);
   endproperty
   a_auto_out: assert property (p_auto_out) else $error("auto inversion not applied");
   property p_rd_status;
      @(posedge sys_clk) disable iff (!rst_n_r)
         !mode_r[PVM_BIT_APOLDIS] && reg_addr == PVM_ADDR_MODE |=> reg_rdata[PVM_BIT_RXINV] == $past(auto_inv_r);
   endproperty
   a_rd_status: assert property (p_rd_status) else $error("polarity status wrong");
   property p_force_inv;
      @(posedge sys_clk) disable iff (!rst_n_r)
         mode_r[PVM_BIT_APOLDIS] |=> rx_invert == $past(mode_r[PVM_BIT_RXINV]);
   endproperty
   a_force_inv: assert property (p_force_inv) else $error("forced inversion wrong");
   property p_wr_inv;
      @(posedge sys_clk) disable iff (!rst_n_r)
         reg_wr && reg_addr == PVM_ADDR_MODE && reg_wdata[PVM_BIT_APOLDIS] |=> mode_r[PVM_BIT_RXINV] == $past(reg_wdata[PVM_BIT_RXINV]);
   endproperty
   a_wr_inv: assert property (p_wr_inv) else $error("inversion bit not written");
   property p_byp_speed;
      @(posedge sys_clk) disable iff (!rst_n_r)
         !hundred_meg |=> !pcs_bypass;
   endproperty
   a_byp_speed: assert property (p_byp_speed) else $error("bypass outside 100 Mb/s");
   property p_byp_on;
      @(posedge sys_clk) disable iff (!rst_n_r)
         mode_r[PVM_BIT_CODING_SUBLAYER_BYPASS] && hundred_meg |=> pcs_bypass;
   endproperty
   a_byp_on: assert property (p_byp_on) else $error("bypass not applied");
   property p_gate_speed;
      @(posedge sys_clk) disable iff (!rst_n_r)
         !hundred_meg |=> !rx_clk_gate_en;
   endproperty
   a_gate_speed: assert property (p_gate_speed) else $error("gating outside 100 Mb/s");
   property p_gate_busy;
      @(posedge sys_clk) disable iff (!rst_n_r)
         rx_activity |=> !rx_clk_gate_en;
   endproperty
   a_gate_busy: assert property (p_gate_busy) else $error("gating while receiving");
   property p_rdata_resv;
      @(posedge sys_clk) disable iff (!rst_n_r)
         reg_addr == PVM_ADDR_MODE |=> (reg_rdata & PVM_RESERVED_MASK) == (PVM_RESET_VAL & PVM_RESERVED_MASK);
   endproperty
   a_rdata_resv: assert property (p_rdata_resv) else $error("reserved read wrong");
   c_write: cover property (@(posedge sys_clk) reg_wr && reg_addr == PVM_ADDR_MODE);
   c_sqe: cover property (@(posedge sys_clk) collision);
   c_gate: cover property (@(posedge sys_clk) rx_clk_gate_en);
   c_inv: cover property (@(posedge sys_clk) rx_invert);
   c_loop: cover property (@(posedge sys_clk) rx_loop_sel);
endmodule : pvm_mode_ctrl

// >>> core/pvm_pkg.sv
// Package: register map, field positions and reset values of the vendor mode control register
package pvm_pkg;
   localparam logic [4:0] PVM_ADDR_MODE = 5'h10;
   localparam int PVM_BIT_RPT = 15;
   localparam int PVM_BIT_IRQPOL = 14;
   localparam int PVM_BIT_TXFLOAT = 12;
   localparam int PVM_BIT_HEARTBEAT_TEST_INHIBIT = 11;
   localparam int PVM_BIT_NLOOP = 10;
   localparam int PVM_BIT_APOLDIS = 5;
   localparam int PVM_BIT_RXINV = 4;
   localparam int PVM_BIT_CODING_SUBLAYER_BYPASS = 1;
   localparam int PVM_BIT_RX_CLOCK_GATING = 0;
   localparam logic [31:0] PVM_RESET_VAL = 32'h0000_0140;
   localparam logic [31:0] PVM_RESERVED_MASK = 32'hFFFF_23CC;
   localparam logic [31:0] PVM_WRITE_MASK = 32'h0000_DC33;
   localparam logic [1:0] PVM_SPEED_10 = 2'h0;
   localparam logic [1:0] PVM_SPEED_100 = 2'h1;
   typedef enum logic [1:0] {PVM_SQE_IDLE, PVM_SQE_ARMED, PVM_SQE_PULSE} pvm_sqe_t;
endpackage : pvm_pkg

// >>> core/pvm_sqe_gen.sv
// Heartbeat test pulse generator after end of transmit
`timescale 1ns/100ps
module pvm_sqe_gen (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic tx_active,
   output logic sqe_pulse
);
   import pvm_pkg::*;
   pvm_sqe_t state_r, state_nxt;
   logic sqe_nxt;
   always_comb begin
      state_nxt = state_r;
      sqe_nxt = 1'b0;
      case (state_r)
         PVM_SQE_IDLE: begin
            if (tx_active) begin
               state_nxt = PVM_SQE_ARMED;
            end
         end
         PVM_SQE_ARMED: begin
            if (!tx_active) begin
               state_nxt = enable ? PVM_SQE_PULSE : PVM_SQE_IDLE;
               sqe_nxt = enable;
            end
         end
         PVM_SQE_PULSE: begin
            state_nxt = tx_active ? PVM_SQE_ARMED : PVM_SQE_IDLE;
         end
         default: begin
            state_nxt = PVM_SQE_IDLE;
         end
      endcase
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= PVM_SQE_IDLE;
         sqe_pulse <= 1'b0;
      end else begin
         state_r <= state_nxt;
         sqe_pulse <= sqe_nxt;
      end
   end
endmodule : pvm_sqe_gen

// >>> verification/pvm_mac_model.sv
// Management side model: register accesses and frame timing
`timescale 1ns/100ps
module pvm_mac_model (
   input wire logic sys_clk,
   input wire logic [31:0] reg_rdata,
   output logic [4:0] reg_addr,
   output logic reg_wr,
   output logic [31:0] reg_wdata,
   output logic tx_activity
);
   import pvm_pkg::*;
   initial begin
      reg_addr = 5'h00;
      reg_wr = 1'b0;
      reg_wdata = 32'h0000_0000;
      tx_activity = 1'b0;
   end
   task automatic wr(input logic [31:0] d);
      logic [31:0] cur;
      logic [31:0] val;
      rd(PVM_ADDR_MODE, cur);
      val = (cur & PVM_RESERVED_MASK) | (d & ~PVM_RESERVED_MASK);
      val[PVM_BIT_IRQPOL] = 1'b0;
      @(posedge sys_clk);
      reg_addr <= PVM_ADDR_MODE;
      reg_wr <= 1'b1;
      reg_wdata <= val;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~val;
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [31:0] q);
      @(posedge sys_clk);
      reg_addr <= a;
      repeat (2) @(posedge sys_clk);
      #1 q = reg_rdata;
   endtask : rd
   task automatic frame(input int n);
      @(posedge sys_clk);
      tx_activity <= 1'b1;
      repeat (n) @(posedge sys_clk);
      tx_activity <= 1'b0;
   endtask : frame
endmodule : pvm_mac_model

// >>> verification/testbench.sv
// Testbench for the vendor mode control register
`timescale 1ns/100ps
module testbench;
   import pvm_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b1;
   logic [1:0] link_speed = PVM_SPEED_10;
   logic full_duplex_req = 1'b1, rx_activity = 1'b0, basic_loop_bit = 1'b0, pol_reversed_det = 1'b0;
   logic phy_irq_event = 1'b0, tx_pair_pos_d = 1'b1, tx_pair_neg_d = 1'b0;
   logic [4:0] reg_addr;
   logic reg_wr, tx_activity, irq_pin, full_duplex_en, carrier_sense, collision;
   logic tx_pair_pos_o, tx_pair_pos_oe, tx_pair_neg_o, tx_pair_neg_oe;
   logic rx_loop_sel, rx_invert, pcs_bypass, rx_clk_gate_en;
   logic [31:0] reg_wdata, reg_rdata, q;
   logic [31:0] hb_data [3] = '{32'h0000_0000, 32'h0000_0800, 32'h0000_8000};
   int bad_count = 0, compares = 0, hits;
   always #12.5 sys_clk = ~sys_clk;
   pvm_mode_ctrl u_pvm_mode_ctrl (.sys_clk, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
      .link_speed, .full_duplex_req, .rx_activity, .tx_activity, .basic_loop_bit, .pol_reversed_det,
      .phy_irq_event, .tx_pair_pos_d, .tx_pair_neg_d, .irq_pin, .full_duplex_en, .carrier_sense,
      .collision, .tx_pair_pos_o, .tx_pair_pos_oe, .tx_pair_neg_o, .tx_pair_neg_oe, .rx_loop_sel,
      .rx_invert, .pcs_bypass, .rx_clk_gate_en);
   pvm_mac_model u_m (.sys_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .tx_activity);
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t pin %b expected %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic settle;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : settle
   task automatic cs_chk(input logic exp);
      fork
         u_m.frame(4);
         begin
            repeat (3) @(posedge sys_clk);
            #1 chk_bit(carrier_sense, exp);
         end
      join
   endtask : cs_chk
   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim
   initial begin
      arst_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      u_m.rd(PVM_ADDR_MODE, q);
      chk_reg(q, PVM_RESET_VAL);
      chk_bit(irq_pin, 1'b1);
      u_m.rd(5'h11, q);
      chk_reg(q, 32'h0000_0000);
      $display("test reset done");
      @(posedge sys_clk);
      phy_irq_event <= 1'b1;
      u_m.wr(32'hFFFF_FFFC);
      settle();
      chk_bit(full_duplex_en, 1'b0);
      chk_bit(tx_pair_pos_oe, 1'b0);
      chk_bit(tx_pair_neg_oe, 1'b0);
      chk_bit(rx_loop_sel, 1'b1);
      chk_bit(rx_invert, 1'b1);
      chk_bit(irq_pin, 1'b0);
      chk_bit(pcs_bypass, 1'b0);
      u_m.rd(PVM_ADDR_MODE, q);
      chk_reg(q, 32'h0000_9D70);
      cs_chk(1'b0);
      @(posedge sys_clk);
      link_speed <= PVM_SPEED_100;
      u_m.wr(32'hFFFF_FFFE);
      settle();
      chk_bit(pcs_bypass, 1'b1);
      chk_bit(rx_loop_sel, 1'b0);
      u_m.wr(32'hFFFF_FFFD);
      settle();
      chk_bit(rx_clk_gate_en, 1'b1);
      @(posedge sys_clk);
      rx_activity <= 1'b1;
      settle();
      chk_bit(rx_clk_gate_en, 1'b0);
      chk_bit(carrier_sense, 1'b1);
      @(posedge sys_clk);
      rx_activity <= 1'b0;
      basic_loop_bit <= 1'b1;
      settle();
      chk_bit(rx_clk_gate_en, 1'b0);
      $display("test modes done");
      @(posedge sys_clk);
      link_speed <= PVM_SPEED_10;
      basic_loop_bit <= 1'b0;
      pol_reversed_det <= 1'b1;
      u_m.wr(32'h0000_0000);
      settle();
      chk_bit(rx_invert, 1'b1);
      chk_bit(full_duplex_en, 1'b1);
      chk_bit(tx_pair_pos_oe, 1'b1);
      chk_bit(tx_pair_pos_o, 1'b1);
      u_m.rd(PVM_ADDR_MODE, q);
      chk_reg(q, 32'h0000_0150);
      cs_chk(1'b1);
      u_m.wr(32'h0000_0020);
      settle();
      chk_bit(rx_invert, 1'b0);
      u_m.rd(PVM_ADDR_MODE, q);
      chk_reg(q, 32'h0000_0160);
      $display("test polarity done");
      for (int i = 0; i < 3; i++) begin
         u_m.wr(hb_data[i]);
         hits = 0;
         fork
            u_m.frame(3);
            repeat (10) begin
               @(posedge sys_clk);
               #1 if (collision === 1'b1) hits++;
            end
         join
         chk_reg(hits, (i == 0) ? 32'h1 : 32'h0);
      end
      $display("test heartbeat done");
      end_sim();
   end
endmodule : testbench
